// File: src/sac_pkg.sv
// Package: constants shared by the sector address checker files.
package sac_pkg;

	// ----------------------------------------------------------------
	// Geometry limits
	// ----------------------------------------------------------------
	localparam logic [28:0] CHS_LIMIT = 29'h0FBFC10; // 16,514,064 sectors.
	localparam logic [28:0] TOT_MAX   = 29'h10000000; // 268,435,456 sectors.
	localparam logic [28:0] TOT_MIN   = 29'h0000001;
	localparam logic [15:0] CYL_BIG   = 16'h3FFF; // Forced cylinders on big media.
	localparam logic [15:0] CYL_MAX   = 16'hFFFF;
	localparam logic [4:0]  HD_MAX    = 5'h10;
	localparam logic [7:0]  DSPT_MAX  = 8'h3F;
	localparam logic [4:0]  DIV_STEPS = 5'h18;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_TOTAL  = 8'h04;
	localparam logic [7:0] OFF_DEFG   = 8'h08;
	localparam logic [7:0] OFF_CURG   = 8'h0C;
	localparam logic [7:0] OFF_CURCAP = 8'h10;
	localparam logic [7:0] OFF_REQ    = 8'h14;
	localparam logic [7:0] OFF_RES    = 8'h18;
	localparam logic [7:0] OFF_RESADR = 8'h1C;
	localparam logic [7:0] OFF_RESLIN = 8'h20;
	localparam logic [7:0] OFF_EVT    = 8'h24;
	localparam logic [7:0] OFF_IRQ    = 8'h28;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int B_CHS_OPT = 0;  // CTRL: offer geometry on big media.
	localparam int B_PKT     = 1;  // CTRL: packet-command device.
	localparam int B_BSY     = 2;  // CTRL: busy flag.
	localparam int B_DRQ     = 3;  // CTRL: data request flag.
	localparam int B_PDRQ_LO = 5;  // CTRL: packet DRQ type, 2 bits.
	localparam int B_LBA     = 28; // REQ: linear addressing form.
	localparam int B_EV_OK   = 0;  // EVT bits, write one to signal.
	localparam int B_EV_ERR  = 1;
	localparam int B_EV_PIO  = 2;
	localparam int B_EV_PKT  = 3;
	localparam int B_EV_OVL  = 4;
	localparam int B_EV_DIAG = 5;
	localparam logic [1:0] PDRQ_IRQ = 2'h1;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SAC_IDLE = 3'h1,
		SAC_DIV  = 3'h2,
		SAC_LOAD = 3'h4
	} sac_state_e;

endpackage : sac_pkg

// File: src/sac_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module sac_sync #(
	parameter int           W    = 2,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset.
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Pins in, filtered levels out.
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sac_sync_s;

	sac_sync_s st;
	sac_sync_s next_st;

	// Stage one feeds only stage two, so a metastable level never reaches logic.
	always_comb begin
		next_st    = st;
		next_st.s1 = d_i;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.q  = (~(st.s2 ^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.q);
		if (rst_i) begin
			next_st = {INIT, INIT, INIT, INIT};
		end
	end

	// State register.
	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign q_o = st.q;

endmodule : sac_sync
`default_nettype wire

// File: src/sac_top.sv
// Sector address translation, geometry words and interrupt pending logic.
`timescale 1ns/1ps
`default_nettype none
module sac_top
	import sac_pkg::*;
#(
	parameter logic [28:0] DEF_TOTAL = 29'h0FBFC10,
	parameter logic [15:0] DEF_CYL   = 16'h3FFF,
	parameter logic [4:0]  DEF_HD    = 5'h10,
	parameter logic [7:0]  DEF_SPT   = 8'h3F
) (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Command block access strobes from the host front end.
	input  wire logic        ata_stat_rd_i,
	input  wire logic        ata_cmd_wr_i,
	input  wire logic        ata_dev_wr_i,
	input  wire logic        ata_dev_i,
	input  wire logic        ata_ctl_wr_i,
	input  wire logic        ata_nien_i,
	input  wire logic        ata_srst_i,
	// Cable pins.
	input  wire logic        ata_reset_n_i,
	input  wire logic        csel_i,
	// Interrupt pin, three signals.
	input  wire logic        intrq_i,
	output logic             intrq_o,
	output logic             intrq_oe_n_o
);
	import sac_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		sac_state_e  fsm;
		logic        ack;
		logic [31:0] dat;
		logic        chs_opt;
		logic        pkt;
		logic        bsy;
		logic        drq;
		logic [1:0]  pdrq;
		logic [28:0] total;
		logic [15:0] dcyl;
		logic [4:0]  dhd;
		logic [7:0]  dspt;
		logic [15:0] ccyl;
		logic [4:0]  chd;
		logic [7:0]  cspt;
		logic [27:0] radr;
		logic [27:0] rlin;
		logic        rlba;
		logic        rerr;
		logic        rdone;
		logic        rinit_err;
		logic [23:0] dvd;
		logic [23:0] quo;
		logic [12:0] dvs;
		logic [13:0] rem;
		logic [4:0]  cnt;
		logic        pend;
		logic        sel;
		logic        nien;
		logic        intrq;
		logic        intrq_oe_n;
	} sac_st_s;

	sac_st_s     st;
	sac_st_s     next_st;
	logic [1:0]  pins;
	logic        hwrst, devnum, chs_en, def_ok, cur_ok, acc, wr;
	logic        chs_err, lba_err, set_any, clr_any, soft_rst;
	logic [15:0] dcyl_raw;
	logic [28:0] dprod, cprod;
	logic [15:0] cc;
	logic [4:0]  ch;
	logic [7:0]  cs;
	logic [28:0] cap;
	logic [31:0] wd;
	logic [7:0]  req_s;
	logic [15:0] req_c;
	logic [3:0]  req_h;
	logic [29:0] lin_chs;
	logic [5:0]  ev;
	logic [13:0] trial;

	// Reset and cable select pins arrive from the cable, so filter them.
	sac_sync #(.W(2), .INIT(2'h1)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({csel_i, ata_reset_n_i}),
		.q_o   (pins)
	);
	assign hwrst  = ~pins[0];
	assign devnum = pins[1];

	// ----------------------------------------------------------------
	// Geometry words
	// ----------------------------------------------------------------
	// Effective default and current words as the host sees them.
	always_comb begin
		chs_en   = (st.total <= CHS_LIMIT) | st.chs_opt;
		dcyl_raw = (st.total >= CHS_LIMIT) ? CYL_BIG : st.dcyl;
		dprod    = 29'(29'(dcyl_raw) * 29'(st.dhd) * 29'(st.dspt));
		def_ok   = chs_en && (dcyl_raw != 16'h0000) && (st.dhd != 5'h00)
			&& (st.dhd <= HD_MAX) && (st.dspt != 8'h00)
			&& (st.dspt <= DSPT_MAX) && (dprod <= CHS_LIMIT);
		cprod  = 29'(29'(st.ccyl) * 29'(st.chd) * 29'(st.cspt));
		cur_ok = def_ok && (cprod <= CHS_LIMIT) && (cprod <= st.total);
		cc  = cur_ok ? st.ccyl : 16'h0000;
		ch  = cur_ok ? st.chd : 5'h00;
		cs  = cur_ok ? st.cspt : 8'h00;
		cap = 29'(29'(cc) * 29'(ch) * 29'(cs));
	end

	// ----------------------------------------------------------------
	// Bus decode and address check
	// ----------------------------------------------------------------
	// Unselected byte lanes are written as zero, so a partial write clears the rest.
	always_comb begin
		acc     = wb_cyc_i & wb_stb_i & ~st.ack;
		wr      = acc & wb_we_i;
		wd      = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		req_s   = wd[7:0];
		req_c   = wd[23:8];
		req_h   = wd[27:24];
		// Geometry number computed from the current translation.
		lin_chs = 30'(30'(30'(21'(req_c) * 21'(st.chd)) + 30'(req_h)) * 30'(st.cspt))
			+ 30'(req_s) - 30'h1;
		chs_err = !def_ok || (req_c >= st.ccyl) || ({1'b0, req_h} >= st.chd)
			|| (req_s == 8'h00) || (req_s > st.cspt) || (lin_chs >= 30'(st.total));
		lba_err = {1'b0, wd[27:0]} >= st.total;
		ev      = (wr && wb_adr_i[7:2] == OFF_EVT[7:2]) ? wd[5:0] : 6'h00;
		// Pending set sources; diagnostic qualified by device role, packet by CTRL pkt and pdrq.
		set_any = ev[B_EV_OK] | ev[B_EV_ERR] | ev[B_EV_PIO] | ev[B_EV_OVL]
			| (ev[B_EV_DIAG] & ~devnum)
			| (ev[B_EV_PKT] & st.pkt & (st.pdrq == PDRQ_IRQ));
		soft_rst = ata_ctl_wr_i & ata_srst_i;
		clr_any  = (ata_stat_rd_i & st.sel & ~st.bsy)
			| (ata_cmd_wr_i & st.sel & ~st.bsy & ~st.drq);
		trial    = {st.rem[12:0], st.dvd[23]};
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.ack = acc;
		// Register writes; current geometry and request writes are dropped outside SAC_IDLE.
		if (wr) begin
			unique case ({wb_adr_i[7:2], 2'h0})
				OFF_CTRL: begin
					next_st.chs_opt = wd[B_CHS_OPT];
					next_st.pkt     = wd[B_PKT];
					next_st.bsy     = wd[B_BSY];
					next_st.drq     = wd[B_DRQ];
					next_st.pdrq    = wd[B_PDRQ_LO+1:B_PDRQ_LO];
				end
				OFF_TOTAL: begin
					// Out-of-range totals saturate rather than wrap.
					if (wd[28:0] < TOT_MIN) begin
						next_st.total = TOT_MIN;
					end else if (wd[31:29] != 3'h0 || wd[28:0] > TOT_MAX) begin
						next_st.total = TOT_MAX;
					end else begin
						next_st.total = wd[28:0];
					end
				end
				OFF_DEFG: begin
					next_st.dcyl = wd[15:0];
					next_st.dhd  = wd[20:16];
					next_st.dspt = wd[31:24];
				end
				OFF_CURG: begin
					// Hosts give heads and sectors; cylinders are divided out.
					if (st.fsm == SAC_IDLE) begin
						if (def_ok && wd[20:16] != 5'h00 && wd[20:16] <= HD_MAX
							&& wd[31:24] != 8'h00) begin
							next_st.chd       = wd[20:16];
							next_st.cspt      = wd[31:24];
							next_st.dvd       = (st.total < CHS_LIMIT) ?
								st.total[23:0] : CHS_LIMIT[23:0];
							next_st.dvs       = 13'(wd[20:16] * wd[31:24]);
							next_st.rem       = 14'h0000;
							next_st.quo       = 24'h000000;
							next_st.cnt       = 5'h00;
							next_st.rinit_err = 1'b0;
							next_st.fsm       = SAC_DIV;
						end else begin
							next_st.rinit_err = 1'b1;
						end
					end
				end
				OFF_REQ: begin
					if (st.fsm == SAC_IDLE) begin
						next_st.radr  = wd[27:0];
						next_st.rlba  = wd[B_LBA];
						next_st.rdone = 1'b1;
						next_st.rerr  = wd[B_LBA] ? lba_err : chs_err;
						next_st.rlin  = wd[B_LBA] ? wd[27:0] : lin_chs[27:0];
					end
				end
				default: ;
			endcase
		end
		// Read data is captured in the accept cycle and shown with ack.
		next_st.dat = 32'h00000000;
		if (acc && !wb_we_i) begin
			unique case ({wb_adr_i[7:2], 2'h0})
				OFF_CTRL:   next_st.dat = {25'h0, st.pdrq, 1'b0, st.drq, st.bsy,
					st.pkt, st.chs_opt};
				OFF_TOTAL:  next_st.dat = {3'h0, st.total};
				OFF_DEFG:   next_st.dat = def_ok ? {st.dspt, 3'h0, st.dhd, dcyl_raw}
					: 32'h00000000;
				OFF_CURG:   next_st.dat = {cs, 3'h0, ch, cc};
				OFF_CURCAP: next_st.dat = {3'h0, cap};
				OFF_RES:    next_st.dat = {27'h0, (st.fsm != SAC_IDLE), st.rinit_err,
					st.rlba, st.rerr, st.rdone};
				OFF_RESADR: next_st.dat = {3'h0, st.rlba, st.radr};
				OFF_RESLIN: next_st.dat = {4'h0, st.rlin};
				OFF_IRQ:    next_st.dat = {26'h0, intrq_i, devnum, st.intrq, st.nien,
					st.sel, st.pend};
				default:    next_st.dat = 32'h00000000;
			endcase
		end
		// Cylinder divider: one restoring step per clock.
		unique case (st.fsm)
			SAC_IDLE: ;
			SAC_DIV: begin
				next_st.dvd = {st.dvd[22:0], 1'b0};
				if (trial >= {1'b0, st.dvs}) begin
					next_st.rem = trial - {1'b0, st.dvs};
					next_st.quo = {st.quo[22:0], 1'b1};
				end else begin
					next_st.rem = trial;
					next_st.quo = {st.quo[22:0], 1'b0};
				end
				next_st.cnt = st.cnt + 5'h01;
				if (st.cnt == DIV_STEPS - 5'h01) begin
					next_st.ccyl = (next_st.quo > 24'(CYL_MAX)) ? CYL_MAX
						: next_st.quo[15:0];
					next_st.fsm  = SAC_IDLE;
				end
			end
			SAC_LOAD: begin
				next_st.ccyl = def_ok ? dcyl_raw : 16'h0000;
				next_st.chd  = def_ok ? st.dhd : 5'h00;
				next_st.cspt = def_ok ? st.dspt : 8'h00;
				next_st.fsm  = SAC_IDLE;
			end
		endcase
		// Host side selection and interrupt disable; deselect keeps pending.
		if (ata_dev_wr_i) begin
			next_st.sel = (ata_dev_i == devnum);
		end
		if (ata_ctl_wr_i) begin
			next_st.nien = ata_nien_i;
		end
		// A new event wins over a register clear in the same cycle.
		if (hwrst || soft_rst) begin
			next_st.pend = 1'b0;
		end else if (set_any) begin
			next_st.pend = 1'b1;
		end else if (clr_any) begin
			next_st.pend = 1'b0;
		end
		// Hardware reset also restores the default translation.
		if (hwrst) begin
			next_st.fsm  = SAC_LOAD;
			next_st.nien = 1'b0;
			next_st.sel  = ~devnum;
		end
		next_st.intrq      = next_st.pend & next_st.sel & ~next_st.nien;
		next_st.intrq_oe_n = ~(next_st.sel & ~next_st.nien);
		if (rst_i) begin
			next_st            = '0;
			next_st.fsm        = SAC_LOAD;
			next_st.total      = DEF_TOTAL;
			next_st.dcyl       = DEF_CYL;
			next_st.dhd        = DEF_HD;
			next_st.dspt       = DEF_SPT;
			next_st.intrq_oe_n = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign wb_ack_o     = st.ack;
	assign wb_dat_o     = st.dat;
	assign intrq_o      = st.intrq;
	assign intrq_oe_n_o = st.intrq_oe_n;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	pend_reset_clr_a: assert property (hwrst || soft_rst |=> !st.pend)
		else $error("pending survived a reset");
	pend_set_a: assert property (set_any && !hwrst && !soft_rst |=> st.pend)
		else $error("event did not set pending");
	diag_dev1_a: assert property (!st.pend && ev == 6'h20 && devnum |=> !st.pend)
		else $error("device one diagnostic set pending");
	desel_keep_a: assert property (st.pend && ata_dev_wr_i && !hwrst && !soft_rst
		&& !clr_any |=> st.pend)
		else $error("deselect cleared pending");
	intrq_drive_a: assert property (st.pend && st.sel && !st.nien
		|-> intrq_o && !intrq_oe_n_o)
		else $error("interrupt not driven");
	intrq_release_a: assert property (!st.sel || st.nien |-> intrq_oe_n_o)
		else $error("interrupt not released");
	lba_range_a: assert property (wr && wb_adr_i[7:2] == OFF_REQ[7:2] && st.fsm == SAC_IDLE
		&& wd[B_LBA] && {1'b0, wd[27:0]} >= st.total |=> st.rerr && st.rlba)
		else $error("linear overrun not flagged");
	reset_geom_a: assert property (st.fsm == SAC_LOAD && !hwrst && def_ok
		|=> st.ccyl == $past(dcyl_raw) && st.chd == $past(st.dhd))
		else $error("current geometry not loaded from default");
	div_time_a: assert property ($rose(st.fsm == SAC_DIV) && !hwrst
		|-> ##[24:25] st.fsm == SAC_IDLE)
		else $error("cylinder division overran");
	cap_limit_a: assert property (st.fsm == SAC_IDLE |-> cap <= CHS_LIMIT
		&& cap <= st.total)
		else $error("current capacity over limit");
	big_cyl_a: assert property (def_ok && st.total >= CHS_LIMIT
		|-> dcyl_raw == CYL_BIG)
		else $error("default cylinders not forced");

endmodule : sac_top
`default_nettype wire

// File: verification/sac_host_model.sv
// Host adapter model: Command Block strobes, cable pins and the INTRQ wire.
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
	// Clock.
	input  wire logic clk_i,
	// Strobes and pins towards the device.
	output logic      stat_rd_o,
	output logic      cmd_wr_o,
	output logic      dev_wr_o,
	output logic      dev_o,
	output logic      ctl_wr_o,
	output logic      nien_o,
	output logic      srst_o,
	output logic      reset_n_o,
	output logic      csel_o,
	// Interrupt wire.
	input  wire logic intrq_i,
	input  wire logic intrq_oe_n_i,
	output logic      intrq_w_o
);
	logic last = 1'b0;

	initial begin
		{stat_rd_o, cmd_wr_o, dev_wr_o, ctl_wr_o} = 4'h0;
		{dev_o, nien_o, srst_o, csel_o} = 4'h0;
		reset_n_o = 1'b1;
	end

	// A released wire shows the inverse of the last driven level, so a stale value never passes.
	always @(posedge clk_i) begin
		if (!intrq_oe_n_i) begin
			last <= intrq_i;
		end
	end
	assign intrq_w_o = intrq_oe_n_i ? ~last : intrq_i;

	// One-cycle register access strobe; 0 status read, 1 command, 2 device/head, 3 control.
	task automatic strobe(input int k, input logic a, input logic b);
		@(posedge clk_i);
		case (k)
			0: stat_rd_o <= 1'b1;
			1: cmd_wr_o <= 1'b1;
			2: begin
				dev_wr_o <= 1'b1;
				dev_o    <= a;
			end
			default: begin
				ctl_wr_o <= 1'b1;
				nien_o   <= a;
				srst_o   <= b;
			end
		endcase
		@(posedge clk_i);
		{stat_rd_o, cmd_wr_o, dev_wr_o, ctl_wr_o} <= 4'h0;
		repeat (2) @(posedge clk_i);
	endtask : strobe

	// Pins change slowly; the wait covers the device's pin filter.
	task automatic pins(input logic rst_n, input logic cs);
		@(posedge clk_i);
		reset_n_o <= rst_n;
		csel_o    <= cs;
		repeat (6) @(posedge clk_i);
	endtask : pins
endmodule : sac_host_model
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the sector address checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sac_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] rd;
	logic        ack;
	logic        s_rd, c_wr, d_wr, dv, k_wr, nien, srst, rst_n, csel;
	logic        intrq, oe_n, intrq_w;
	int          errors = 0;
	int          num_checks = 0;
	int          cycles = 0;
	int          k;
	logic [31:0] reqs [8] = '{32'h10FBFC0F, 32'h10FBFC10, 32'h00000001, 32'h02000103,
		32'h02000100, 32'h003FFF01, 32'h0F3FFE3F, 32'h00000040};
	logic [31:0] ress [8] = '{32'h5, 32'h7, 32'h1, 32'h1, 32'h3, 32'h3, 32'h1, 32'h3};
	logic [31:0] lins [8] = '{32'hFBFC0F, 0, 0, 32'h470, 0, 0, 32'hFBFC0F, 0};

	always #2.5 clk_i = ~clk_i;

	sac_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .ata_stat_rd_i(s_rd), .ata_cmd_wr_i(c_wr),
		.ata_dev_wr_i(d_wr), .ata_dev_i(dv), .ata_ctl_wr_i(k_wr), .ata_nien_i(nien),
		.ata_srst_i(srst), .ata_reset_n_i(rst_n), .csel_i(csel), .intrq_i(intrq_w),
		.intrq_o(intrq), .intrq_oe_n_o(oe_n));

	sac_host_model host_u (.clk_i(clk_i), .stat_rd_o(s_rd), .cmd_wr_o(c_wr),
		.dev_wr_o(d_wr), .dev_o(dv), .ctl_wr_o(k_wr), .nien_o(nien), .srst_o(srst),
		.reset_n_o(rst_n), .csel_o(csel), .intrq_i(intrq), .intrq_oe_n_i(oe_n),
		.intrq_w_o(intrq_w));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	// The run is a few hundred cycles; the ceiling only catches a hang.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			print_verdict();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Classic single Wishbone cycle, held until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		we  <= 1'b0;
	endtask : wb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
		wb(1'b0, a, 32'h0);
		check(name, rd, exp);
	endtask : rdchk

	// Pending bit, and the pin pair {released, level}.
	task automatic irqchk(input logic pend, input logic [1:0] pin, input string name);
		wb(1'b0, OFF_IRQ, 32'h0);
		check(name, {rd[0], oe_n, intrq}, {pend, pin});
	endtask : irqchk

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rdchk(OFF_TOTAL, 32'h00FBFC10, "total");
		rdchk(OFF_DEFG, 32'h3F103FFF, "defg");
		rdchk(OFF_CURG, 32'h3F103FFF, "curg");
		rdchk(OFF_CURCAP, 32'h00FBFC10, "curcap");
		wb(1'b1, 8'h3C, 32'hFFFFFFFF);
		rdchk(8'h3C, 32'h0, "unmapped");
		wb(1'b1, OFF_TOTAL, 32'h0);
		rdchk(OFF_TOTAL, 32'h1, "tot_lo");
		wb(1'b1, OFF_TOTAL, 32'h1FFFFFFF);
		rdchk(OFF_TOTAL, 32'h10000000, "tot_hi");
		rdchk(OFF_DEFG, 32'h0, "no_chs");
		rdchk(OFF_CURCAP, 32'h0, "no_cap");
		wb(1'b1, OFF_CTRL, 32'h1);
		rdchk(OFF_DEFG, 32'h3F103FFF, "opt_chs");
		wb(1'b1, OFF_TOTAL, 32'h00FBFC10);
		wb(1'b1, OFF_CTRL, 32'h0);
		$display("test capacity done");
		// Both address forms are chosen per request by bit 28.
		for (k = 0; k < 8; k++) begin
			wb(1'b1, OFF_REQ, reqs[k]);
			rdchk(OFF_RES, ress[k], "res");
			rdchk(OFF_RESADR, reqs[k], "resadr");
			if (ress[k][1] == 1'b0) begin
				rdchk(OFF_RESLIN, lins[k], "reslin");
			end
		end
		$display("test address done");
		wb(1'b1, OFF_CURG, 32'hFF000000);
		rdchk(OFF_RES, 32'hB, "geom_bad");
		// 16 heads of 255 sectors: 16514064 / 4080 gives 4047 cylinders.
		wb(1'b1, OFF_CURG, 32'hFF100000);
		do wb(1'b0, OFF_RES, 32'h0); while (rd[4] !== 1'b0);
		rdchk(OFF_CURG, 32'hFF100FCF, "div");
		rdchk(OFF_CURCAP, 32'h00FBF310, "divcap");
		wb(1'b1, OFF_REQ, 32'h000001FF);
		rdchk(OFF_RESLIN, 32'h10EE, "newlin");
		$display("test geometry done");
		host_u.strobe(2, 1'b0, 1'b0);
		host_u.strobe(3, 1'b0, 1'b0);
		for (k = 0; k < 6; k++) begin
			if (k != B_EV_PKT) begin
				wb(1'b1, OFF_EVT, 32'h1 << k);
				irqchk(1'b1, 2'b01, "event");
				host_u.strobe(1, 1'b0, 1'b0);
				irqchk(1'b0, 2'b00, "cmd_clr");
				check("wire", intrq_w, 1'b0);
			end
		end
		wb(1'b1, OFF_EVT, 32'h1);
		host_u.strobe(2, 1'b1, 1'b0);
		irqchk(1'b1, 2'b10, "desel");
		host_u.strobe(2, 1'b0, 1'b0);
		irqchk(1'b1, 2'b01, "resel");
		host_u.strobe(3, 1'b1, 1'b0);
		irqchk(1'b1, 2'b10, "nien");
		host_u.strobe(3, 1'b0, 1'b0);
		wb(1'b1, OFF_CTRL, 32'h4);
		host_u.strobe(0, 1'b0, 1'b0);
		irqchk(1'b1, 2'b01, "bsy_rd");
		wb(1'b1, OFF_CTRL, 32'h8);
		host_u.strobe(1, 1'b0, 1'b0);
		irqchk(1'b1, 2'b01, "drq_wr");
		host_u.strobe(0, 1'b0, 1'b0);
		irqchk(1'b0, 2'b00, "stat_clr");
		wb(1'b1, OFF_CTRL, 32'h42);
		wb(1'b1, OFF_EVT, 32'h8);
		irqchk(1'b0, 2'b00, "pkt_10");
		wb(1'b1, OFF_CTRL, 32'h22);
		wb(1'b1, OFF_EVT, 32'h8);
		irqchk(1'b1, 2'b01, "pkt_01");
		host_u.strobe(3, 1'b0, 1'b1);
		host_u.strobe(3, 1'b0, 1'b0);
		irqchk(1'b0, 2'b00, "srst");
		wb(1'b1, OFF_EVT, 32'h1);
		host_u.pins(1'b0, 1'b0);
		host_u.pins(1'b1, 1'b0);
		irqchk(1'b0, 2'b00, "pin_rst");
		rdchk(OFF_CURG, 32'h3F103FFF, "reload");
		host_u.pins(1'b1, 1'b1);
		wb(1'b1, OFF_EVT, 32'h20);
		irqchk(1'b0, 2'b00, "diag1");
		wb(1'b1, OFF_EVT, 32'h2);
		wb(1'b0, OFF_IRQ, 32'h0);
		check("dev1_err", {rd[4], rd[0]}, 2'b11);
		$display("test interrupt done");
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
